// ---- include/ifeb_pkg.sv ----
// Package of constants for the interrupt flag and enable bank.
// Assumes an APB register port with 32-bit data on a single clock.
//
// What this block does
// - Flag reads one after a recorded request.
// - Enable bit one lets request proceed.
// - Implemented bits read/write, zero after reset.
// - Unimplemented bit positions always read zero.
// - Flag two upper byte source layout.
// - Flag two lower byte source layout.
// - Flag three upper byte source layout.
// - Flag three lower byte source layout.
// - Flag four source layout.
// - Enable zero bits seven to three.
// - Enable zero bits two to zero.
package ifeb_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets.
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_FLAG2 = 8'h00; // Flag register two.
	localparam logic [7:0] OFS_FLAG3 = 8'h04; // Flag register three.
	localparam logic [7:0] OFS_FLAG4 = 8'h08; // Flag register four.
	localparam logic [7:0] OFS_EN0 = 8'h0C; // Enable register zero.
	localparam logic [7:0] OFS_ISTAT = 8'h10; // Sticky event status.
	localparam logic [7:0] OFS_ICLR = 8'h14; // Event clear, write only.
	localparam logic [7:0] OFS_IEN = 8'h18; // Event interrupt enable.

	// ----------------------------------------------------------------
	// Implemented-bit masks and reset values.
	// ----------------------------------------------------------------
	localparam logic [15:0] MASK_FLAG2 = 16'hDFFF; // Bit 13 absent.
	localparam logic [15:0] MASK_FLAG3 = 16'h39FF; // 15-14, 10-9 absent.
	localparam logic [15:0] MASK_FLAG4 = 16'h00F6; // 15-8, 3, 0 absent.
	localparam logic [15:0] MASK_EN0 = 16'h7FFF; // Bit 15 absent.
	localparam logic [15:0] RST_REG = 16'h0000; // All bits clear at reset.

	// Event status bits: one per flag register, set on any source pulse to that register.
	localparam int EV_W = 3;
	localparam logic [EV_W-1:0] RST_EV = 3'h0;

	// Top-of-word padding for 16-bit registers on a 32-bit bus.
	localparam logic [15:0] PAD_HI = 16'h0000;

endpackage

// ---- include/ifeb_reg_if.sv ----
// Interface carrying one flag register's write strobe and state.
// Assumes both ends run on the same pclk.
`timescale 1ns/10ps
interface ifeb_reg_if;
	logic wr; // One-cycle software write strobe.
	logic [15:0] wdata; // Software write data.
	logic [15:0] src; // Source request pulses.
	logic [15:0] value; // Current register contents.

	// Bus side drives strobes, the flag module answers with value.
	modport bus (output wr, output wdata, output src, input value);
	modport flags (input wr, input wdata, input src, output value);
endinterface

// ---- sim/ifeb_bank_bench.sv ----
// Self-checking bench for the flag and enable bank over APB.
// Assumes the design answers each access with one registered pready.
`timescale 1ns/10ps
module ifeb_bank_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, go = 1'b0, pready, pslverr, irq, err_q;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_q;
	logic [1:0] sel = 2'h0;
	logic [15:0] bits = 16'h0000, s2, s3, s4, p2, p3, p4;
	logic [14:0] pen;
	int miscompares = 0, tests_run = 0, cyc = 0;

	// ------------------------------------------------------------
	// Clock, timeout and instances
	// ------------------------------------------------------------
	initial
	begin
		forever #20 pclk = ~pclk;
	end
	// A hang is cut short well past the expected run length.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			miscompares++;
			stop_test();
		end
	end
	ifeb_src_model srcs (.pclk(pclk), .presetn(presetn), .go(go),
		.sel(sel), .bits(bits), .src_flag2(s2), .src_flag3(s3),
		.src_flag4(s4));
	ifeb_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_flag2(s2), .src_flag3(s3),
		.src_flag4(s4), .pend_en0(pen), .pend_flag2(p2),
		.pend_flag3(p3), .pend_flag4(p4), .irq(irq));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
	begin
		tests_run++;
		if (g !== e)
		begin
			$display("BAD %s expected %h saw %h", nm, e, g);
			miscompares++;
		end
	end
	endtask
	// One APB transfer; held until pready is seen high at an edge.
	// The request stands until the rising edge that samples pready high;
	// data and error are taken at that edge, then the request is dropped.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	// Reads a register and compares the word.
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
	begin
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd_q);
	end
	endtask
	// Asks the source model for one pulse on flag register two, three or four (k = 0, 1, 2).
	task automatic fire(input logic [1:0] k, input logic [15:0] v);
	begin
		@(posedge pclk);
		go <= 1'b1;
		sel <= k;
		bits <= v;
		@(posedge pclk);
		go <= 1'b0;
		repeat (3) @(posedge pclk);
	end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values and the unmapped-address refusal.
	task automatic t_reset();
	begin
		rd("flag2", ifeb_pkg::OFS_FLAG2, 32'h0);
		rd("flag3", ifeb_pkg::OFS_FLAG3, 32'h0);
		rd("flag4", ifeb_pkg::OFS_FLAG4, 32'h0);
		rd("en0", ifeb_pkg::OFS_EN0, 32'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped", 32'h0, rd_q);
		chk("unmapped err", 32'h1, {31'h0, err_q});
		$display("reset test done");
	end
	endtask
	// Writes all ones, then zero to flag two and 5 to enable zero; absent bits must read zero.
	task automatic t_write();
	begin
		apb(1'b1, ifeb_pkg::OFS_FLAG2, 32'hFFFFFFFF);
		rd("flag2 ones", 8'h00, 32'h0000DFFF);
		apb(1'b1, ifeb_pkg::OFS_EN0, 32'hFFFFFFFF);
		rd("en0 ones", 8'h0C, 32'h00007FFF);
		chk("en0 mid", 32'h000000F8, rd_q & 32'h000000F8);
		chk("pend_en0", 32'h7FFF, {17'h0, pen});
		apb(1'b1, ifeb_pkg::OFS_FLAG2, 32'h0);
		rd("flag2 zero", 8'h00, 32'h0);
		apb(1'b1, ifeb_pkg::OFS_EN0, 32'h00000005);
		rd("en0 low", 8'h0C, 32'h00000005);
		$display("write test done");
	end
	endtask
	// Source pulses set every implemented flag in all three registers.
	task automatic t_src();
	begin
		fire(2'h0, 16'hFFFF);
		chk("pend_flag2", 32'hDFFF, {16'h0, p2});
		rd("flag2 src", 8'h00, 32'h0000DFFF);
		chk("flag2 low", 32'h000000FF, rd_q & 32'h000000FF);
		fire(2'h1, 16'hFFFF);
		chk("pend_flag3", 32'h39FF, {16'h0, p3});
		rd("flag3 src", 8'h04, 32'h000039FF);
		chk("flag3 low", 32'h000000FF, rd_q & 32'h000000FF);
		fire(2'h2, 16'hFFFF);
		chk("pend_flag4", 32'h00F6, {16'h0, p4});
		rd("flag4 src", 8'h08, 32'h000000F6);
		apb(1'b1, 8'h04, 32'h00000100);
		rd("flag3 clr", 8'h04, 32'h00000100);
		$display("source test done");
	end
	endtask
	// Event interrupt raised, cleared and masked.
	task automatic t_irq();
	begin
		apb(1'b1, ifeb_pkg::OFS_ICLR, 32'h7);
		apb(1'b1, ifeb_pkg::OFS_IEN, 32'h1);
		fire(2'h0, 16'h0001);
		chk("irq on", 32'h1, {31'h0, irq});
		rd("istat", ifeb_pkg::OFS_ISTAT, 32'h1);
		apb(1'b1, ifeb_pkg::OFS_ICLR, 32'h7);
		repeat (3) @(posedge pclk);
		chk("irq off", 32'h0, {31'h0, irq});
		fire(2'h1, 16'h0001);
		chk("irq masked", 32'h0, {31'h0, irq});
		rd("istat 3", 8'h10, 32'h2);
		$display("interrupt test done");
	end
	endtask

	// ------------------------------------------------------------
	// Main sequence and verdict
	// ------------------------------------------------------------
	task automatic stop_test();
	begin
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_write();
		t_src();
		t_irq();
		stop_test();
	end
endmodule

// ---- sim/ifeb_src_model.sv ----
// Model of the peripherals that raise request pulses into the bank.
// Assumes the bench asks for a pulse by holding go for one pclk cycle.
`timescale 1ns/10ps
module ifeb_src_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [1:0] sel,
	input wire logic [15:0] bits,
	output logic [15:0] src_flag2,
	output logic [15:0] src_flag3,
	output logic [15:0] src_flag4
);
	// ------------------------------------------------------------
	// Pulse generation
	// ------------------------------------------------------------
	// Each request is a one-cycle pulse, so a stuck source is never seen.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_flag2 <= 16'h0000;
			src_flag3 <= 16'h0000;
			src_flag4 <= 16'h0000;
		end
		else
		begin
			src_flag2 <= (go && sel == 2'h0) ? bits : 16'h0000;
			src_flag3 <= (go && sel == 2'h1) ? bits : 16'h0000;
			src_flag4 <= (go && sel == 2'h2) ? bits : 16'h0000;
		end
	end
endmodule

// ---- verilog/ifeb_bank.sv ----
// Top of the interrupt flag and enable bank with its APB slave.
// Assumes APB master on pclk and source pulses synchronous to pclk.
`timescale 1ns/10ps
module ifeb_bank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] src_flag2,
	input wire logic [15:0] src_flag3,
	input wire logic [15:0] src_flag4,
	output logic [14:0] pend_en0,
	output logic [15:0] pend_flag2,
	output logic [15:0] pend_flag3,
	output logic [15:0] pend_flag4,
	output logic irq
);

	// ----------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------
	// The write strobe marks the single APB access edge.
	logic wr_stb;
	logic rd_stb;
	assign wr_stb = psel && penable && pwrite && !pready;
	assign rd_stb = psel && penable && !pwrite && !pready;

	// Decodes one offset match, used for every register.
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// Legal address check, used by the error answer.
	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, ifeb_pkg::OFS_FLAG2) || hit(a, ifeb_pkg::OFS_FLAG3)
			|| hit(a, ifeb_pkg::OFS_FLAG4) || hit(a, ifeb_pkg::OFS_EN0)
			|| hit(a, ifeb_pkg::OFS_ISTAT) || hit(a, ifeb_pkg::OFS_ICLR)
			|| hit(a, ifeb_pkg::OFS_IEN);
	endfunction

	// ----------------------------------------------------------------
	// Flag registers, one instance each.
	// ----------------------------------------------------------------
	ifeb_reg_if f2 ();
	ifeb_reg_if f3 ();
	ifeb_reg_if f4 ();

	// Each flag register sees its write strobe and its source pulses.
	assign f2.wr = wr_stb && hit(paddr, ifeb_pkg::OFS_FLAG2);
	assign f3.wr = wr_stb && hit(paddr, ifeb_pkg::OFS_FLAG3);
	assign f4.wr = wr_stb && hit(paddr, ifeb_pkg::OFS_FLAG4);
	assign f2.wdata = pwdata[15:0];
	assign f3.wdata = pwdata[15:0];
	assign f4.wdata = pwdata[15:0];
	// Bit map: 15 timer6, 14 dma4, 12-9 compare8-5, 8 capture6,
	// 7-5 capture5-3, 4 dma3, 3-2 can one, 1-0 serial port two.
	assign f2.src = src_flag2;
	// Bit map: 13 dma5, 12-11 converter, 8-7 can two, 6-5 ext irq,
	// 4-3 timer9-8, 2-1 two-wire two, 0 timer7.
	assign f3.src = src_flag3;
	// Bit map: 7-6 can tx, 5-4 dma7-6, 2-1 uart errors.
	assign f4.src = src_flag4;

	ifeb_flag_reg #(.MASK(ifeb_pkg::MASK_FLAG2)) u_flag2 (
		.pclk(pclk),
		.presetn(presetn),
		.r(f2.flags)
	);
	ifeb_flag_reg #(.MASK(ifeb_pkg::MASK_FLAG3)) u_flag3 (
		.pclk(pclk),
		.presetn(presetn),
		.r(f3.flags)
	);
	ifeb_flag_reg #(.MASK(ifeb_pkg::MASK_FLAG4)) u_flag4 (
		.pclk(pclk),
		.presetn(presetn),
		.r(f4.flags)
	);

	// ----------------------------------------------------------------
	// Enable register zero.
	// ----------------------------------------------------------------
	// Bit map: 14 dma1, 13 adc one, 12-11 uart one tx/rx,
	// 10-9 serial port one, 8 timer3, 7 timer2, 6 compare2,
	// 5 capture2, 4 dma0, 3 timer1, 2 compare1, 1 capture1, 0 ext irq0.
	logic [15:0] en0_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			en0_q <= ifeb_pkg::RST_REG;
		else if (wr_stb && hit(paddr, ifeb_pkg::OFS_EN0))
			en0_q <= pwdata[15:0] & ifeb_pkg::MASK_EN0;
	end

	// ----------------------------------------------------------------
	// Pending outputs toward the priority logic.
	// ----------------------------------------------------------------
	// Enable zero gates its own sources, which arrive as pending
	// requests from flag register zero outside this block; here the
	// enable mask itself is presented as the allow vector.
	// Flag registers with no enable here present their flags directly.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_en0 <= 15'h0000;
			pend_flag2 <= ifeb_pkg::RST_REG;
			pend_flag3 <= ifeb_pkg::RST_REG;
			pend_flag4 <= ifeb_pkg::RST_REG;
		end
		else
		begin
			pend_en0 <= en0_q[14:0];
			pend_flag2 <= f2.value;
			pend_flag3 <= f3.value;
			pend_flag4 <= f4.value;
		end
	end

	// ----------------------------------------------------------------
	// Event status, clear and enable for the interrupt output.
	// ----------------------------------------------------------------
	logic [ifeb_pkg::EV_W-1:0] ev_stat_q;
	logic [ifeb_pkg::EV_W-1:0] ev_en_q;
	logic [ifeb_pkg::EV_W-1:0] ev_set;
	logic [ifeb_pkg::EV_W-1:0] ev_clr;
	// An event is any source pulse landing in a flag register.
	assign ev_set = {|src_flag4, |src_flag3, |src_flag2};
	assign ev_clr = (wr_stb && hit(paddr, ifeb_pkg::OFS_ICLR)) ?
		pwdata[ifeb_pkg::EV_W-1:0] : ifeb_pkg::RST_EV;

	// Sticky status: a new event wins over a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ev_stat_q <= ifeb_pkg::RST_EV;
		else
			ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
	end

	// Event interrupt enable register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ev_en_q <= ifeb_pkg::RST_EV;
		else if (wr_stb && hit(paddr, ifeb_pkg::OFS_IEN))
			ev_en_q <= pwdata[ifeb_pkg::EV_W-1:0];
	end

	// Level interrupt, registered.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(ev_stat_q & ev_en_q);
	end

	// ----------------------------------------------------------------
	// APB answer: one wait state, error on unmapped addresses.
	// ----------------------------------------------------------------
	logic [15:0] rd_mux;
	always_comb
	begin
		rd_mux = 16'h0000;
		if (hit(paddr, ifeb_pkg::OFS_FLAG2))
			rd_mux = f2.value;
		else if (hit(paddr, ifeb_pkg::OFS_FLAG3))
			rd_mux = f3.value;
		else if (hit(paddr, ifeb_pkg::OFS_FLAG4))
			rd_mux = f4.value;
		else if (hit(paddr, ifeb_pkg::OFS_EN0))
			rd_mux = en0_q;
		else if (hit(paddr, ifeb_pkg::OFS_ISTAT))
			rd_mux = {13'h0000, ev_stat_q};
		else if (hit(paddr, ifeb_pkg::OFS_IEN))
			rd_mux = {13'h0000, ev_en_q};
	end

	// Pready pulses for one cycle in the second access cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped(paddr);
			if (rd_stb)
				prdata <= {ifeb_pkg::PAD_HI, rd_mux};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	AST_EN0_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_stb && hit(paddr, ifeb_pkg::OFS_EN0)) |=>
		en0_q == ($past(pwdata[15:0]) & ifeb_pkg::MASK_EN0))
		else $error("enable write not stored");

	AST_EN0_BIT15: assert property (@(posedge pclk) disable iff (!presetn)
		en0_q[15] == 1'b0)
		else $error("enable bit 15 set");

	AST_PEND_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
		##1 pend_en0 == $past(en0_q[14:0]))
		else $error("pending does not follow enable");

	AST_FLAG2_SRC: assert property (@(posedge pclk) disable iff (!presetn)
		src_flag2[15] |-> ##2 pend_flag2[15])
		else $error("timer six pulse not pending");

	AST_FLAG3_SRC: assert property (@(posedge pclk) disable iff (!presetn)
		src_flag3[13] |-> ##2 pend_flag3[13])
		else $error("dma five pulse not pending");

	AST_FLAG4_SRC: assert property (@(posedge pclk) disable iff (!presetn)
		src_flag4[7] |-> ##2 pend_flag4[7])
		else $error("can two tx pulse not pending");

	AST_FLAG3_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		pend_flag3[10:9] == 2'b00)
		else $error("flag three gap bit set");

	AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("ready not a single pulse");

	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		(|(ev_stat_q & ev_en_q)) |=> irq)
		else $error("interrupt not raised");

endmodule

// ---- verilog/ifeb_flag_reg.sv ----
// Holds one 16-bit interrupt flag register with sticky source bits.
// Assumes source pulses are synchronous to pclk.
`timescale 1ns/10ps
module ifeb_flag_reg #(
	parameter logic [15:0] MASK = 16'hFFFF
) (
	input wire logic pclk,
	input wire logic presetn,
	ifeb_reg_if.flags r
);

	// Stored flag bits.
	logic [15:0] flag_q;
	logic [15:0] flag_d;

	// ----------------------------------------------------------------
	// Next-value logic.
	// ----------------------------------------------------------------
	// A source pulse wins over a software clear in the same cycle.
	always_comb
	begin
		flag_d = flag_q;
		if (r.wr)
		begin
			flag_d = r.wdata;
		end
		flag_d = (flag_d | r.src) & MASK;
	end

	// Flag storage, clear at reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_q <= ifeb_pkg::RST_REG;
		else
			flag_q <= flag_d;
	end

	assign r.value = flag_q;

	// A pulse on source bit 0, where implemented, sets flag bit 0 next cycle.
	AST_PULSE_SETS: assert property (@(posedge pclk) disable iff (!presetn)
		(r.src[0] && MASK[0]) |=> flag_q[0])
		else $error("source pulse did not set flag");

	// Unimplemented bits never read one.
	AST_UNIMP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		(flag_q & ~MASK) == 16'h0000)
		else $error("unimplemented flag bit set");

	// Without pulse or write, a flag holds its value.
	AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(!r.wr && r.src == 16'h0000) |=> flag_q == $past(flag_q))
		else $error("flag changed without cause");

endmodule
